// >>> uop_alu_defines.vh
// constants for the integer execute unit: register map, opcodes, flag layout
//
// Summary of operation
// RULE1 - each uop carries a 2-bit size shift field: 1, 2, 4 or 8 bytes
// RULE2 - size 0: low byte is result, upper seven bytes from first source
// RULE3 - size 1: low two bytes are result, upper six bytes from first source
// RULE4 - size 2: low four bytes are result, upper four bytes zeroed
// RULE5 - size 3: all eight bytes are result, first source ignored
// RULE6 - flags come from the result at operation width, not merged value
// RULE7 - condition evaluation tests zps, carry, overflow flags, giving 1 or 0
// RULE8 - sign extension copies bit N upward to bit 63, N defaults to width
// RULE9 - logical ops: move, and, or, xor, andnot, ornot, nand, nor, xnor
// RULE10 - adder does add, sub and add/sub plus shifted third operand
// RULE11 - add/sub with carry use only third operand's carry flag
// RULE12 - masked add/sub AND result with third operand before merging
// RULE13 - select passes second or first source with its flags per condition
// RULE14 - select valid if chosen input valid; invalid condition makes invalid
// RULE15 - select never issues while any input is waiting
// RULE16 - conditional set gives 0/1 merged into second operand, condition flags out
// RULE17 - fused compare-set merges 0/1 into third operand, comparison flags out
// RULE18 - branch sets pointer to taken target if true, else sequential, no flags
// RULE19 - sequential target selected raises mispredict exception
// RULE20 - decoder swaps targets and flips condition bit 0 for not-taken prediction
// RULE21 - branch target outside executable pages raises execute page fault
// RULE22 - fused compare-branch steers pointer like branch and passes comparison flags
`ifndef UOP_ALU_DEFINES_VH
`define UOP_ALU_DEFINES_VH

`define REG_CTRL 8'h00
`define REG_PAGE_BASE 8'h04
`define REG_PAGE_LIMIT 8'h08
`define REG_MISP_COUNT 8'h0C
`define REG_FAULT_COUNT 8'h10
`define CTRL_ENABLE_BIT 0
`define CTRL_FAULT_CHECK_BIT 1
`define CTRL_RESET 32'h00000003
`define PAGE_BASE_RESET 32'h00000000
`define PAGE_LIMIT_RESET 32'hFFFFFFFF
`define PAGE_LSB 12

// operand flag bundle
`define FLAG_WIDTH 7
`define FL_CF 0
`define FL_ZF 1
`define FL_PF 2
`define FL_SF 3
`define FL_OF 4
`define FL_INV 5
`define FL_WAIT 6

`define OP_MOV 5'h00
`define OP_AND 5'h01
`define OP_OR 5'h02
`define OP_XOR 5'h03
`define OP_ANDNOT 5'h04
`define OP_ORNOT 5'h05
`define OP_NAND 5'h06
`define OP_NOR 5'h07
`define OP_XNOR 5'h08
`define OP_ADD 5'h09
`define OP_SUB 5'h0A
`define OP_ADDA 5'h0B
`define OP_ADDS 5'h0C
`define OP_ADDM 5'h0D
`define OP_SUBM 5'h0E
`define OP_ADDC 5'h0F
`define OP_SUBC 5'h10
`define OP_SEL 5'h11
`define OP_SET 5'h12
`define OP_SET_SUB 5'h13
`define OP_SET_AND 5'h14
`define OP_BR 5'h15
`define OP_COMPARE_DIFF_BRANCH 5'h16
`define OP_COMPARE_MASK_BRANCH 5'h17

`endif

// >>> uop_alu_branch_unit.v
// integer execute unit: size merging, logic, add/sub, select/set, branches
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ns
`include "uop_alu_defines.vh"

module uop_alu_branch_unit #(
	parameter DATA_W = 64
) (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// uop from issue
	input wire uop_valid,
	input wire [4:0] opcode,
	input wire [1:0] size_shift_field,
	input wire [3:0] cond_code,
	input wire [1:0] shift_amount,
	input wire [DATA_W-1:0] ra,
	input wire [DATA_W-1:0] rb,
	input wire [DATA_W-1:0] rc,
	input wire [`FLAG_WIDTH-1:0] ra_flags,
	input wire [`FLAG_WIDTH-1:0] rb_flags,
	input wire [`FLAG_WIDTH-1:0] rc_flags,
	input wire [DATA_W-1:0] rip_taken,
	input wire [DATA_W-1:0] rip_seq,
	// result to pipeline
	output reg res_valid,
	output reg res_refused,
	output reg [DATA_W-1:0] res_data,
	output reg [`FLAG_WIDTH-1:0] res_flags,
	output reg rip_write,
	output reg [DATA_W-1:0] rip_next,
	output reg mispredict_exception,
	output reg exec_page_fault
);

	// width in bits minus one for a size shift value
	function [5:0] top_bit;
		input [1:0] sz;
		begin
			top_bit = (6'd8 << sz) - 6'd1; // [RULE1]
		end
	endfunction

	function [63:0] width_mask;
		input [1:0] sz;
		begin
			case (sz)
				2'd0: width_mask = 64'h00000000000000FF;
				2'd1: width_mask = 64'h000000000000FFFF;
				2'd2: width_mask = 64'h00000000FFFFFFFF;
				default: width_mask = 64'hFFFFFFFFFFFFFFFF;
			endcase
		end
	endfunction

	// copies bit n upward through bit 63
	function [63:0] sign_extend_op;
		input [63:0] val;
		input [5:0] n;
		reg [63:0] keep;
		begin
			keep = {64{1'b1}} >> (6'd63 - n);
			sign_extend_op = val[n] ? (val | ~keep) : (val & keep); // [RULE8]
		end
	endfunction

	function [63:0] merge;
		input [63:0] res;
		input [63:0] base;
		input [1:0] sz;
		begin
			case (sz)
				2'd0: merge = {base[63:8], res[7:0]}; // [RULE2]
				2'd1: merge = {base[63:16], res[15:0]}; // [RULE3]
				2'd2: merge = {32'h00000000, res[31:0]}; // [RULE4]
				default: merge = res; // [RULE5]
			endcase
		end
	endfunction

	// zero, parity, sign from the width-limited value
	function [`FLAG_WIDTH-1:0] zps_of;
		input [63:0] res;
		input [1:0] sz;
		reg [63:0] ext;
		begin
			ext = sign_extend_op(res, top_bit(sz));
			zps_of = {`FLAG_WIDTH{1'b0}};
			zps_of[`FL_ZF] = ((res & width_mask(sz)) == 64'h0000000000000000); // [RULE6]
			zps_of[`FL_PF] = ~(^res[7:0]);
			zps_of[`FL_SF] = ext[63];
		end
	endfunction

	// bit 0 of the code inverts the test
	function flag_condition_eval;
		input [`FLAG_WIDTH-1:0] f;
		input [3:0] cc;
		reg t;
		begin
			case (cc[3:1])
				3'd0: t = f[`FL_OF];
				3'd1: t = f[`FL_CF];
				3'd2: t = f[`FL_ZF];
				3'd3: t = f[`FL_CF] | f[`FL_ZF];
				3'd4: t = f[`FL_SF];
				3'd5: t = f[`FL_PF];
				3'd6: t = f[`FL_SF] ^ f[`FL_OF];
				default: t = f[`FL_ZF] | (f[`FL_SF] ^ f[`FL_OF]);
			endcase
			flag_condition_eval = t ^ cc[0]; // [RULE7]
		end
	endfunction

	// register file
	reg [31:0] ctrl_q;
	reg [31:0] page_base_q;
	reg [31:0] page_limit_q;
	reg [31:0] misp_count_q;
	reg [31:0] fault_count_q;

	wire apb_setup = psel & ~penable;
	wire apb_write = psel & penable & pready & pwrite;
	reg addr_hit;
	reg [31:0] rd_mux;

	always @*
	begin
		addr_hit = 1'b1;
		case (paddr)
			`REG_CTRL: rd_mux = ctrl_q;
			`REG_PAGE_BASE: rd_mux = page_base_q;
			`REG_PAGE_LIMIT: rd_mux = page_limit_q;
			`REG_MISP_COUNT: rd_mux = misp_count_q;
			`REG_FAULT_COUNT: rd_mux = fault_count_q;
			default:
			begin
				rd_mux = 32'h00000000;
				addr_hit = 1'b0;
			end
		endcase
	end

	// datapath
	wire [63:0] msk = width_mask(size_shift_field);
	wire [5:0] tb = top_bit(size_shift_field);
	wire [63:0] am = ra & msk;
	wire [63:0] bm = rb & msk;
	wire [63:0] shifted_c = rc << shift_amount;
	reg [63:0] logic_res;
	reg [64:0] arith_full;
	reg [63:0] arith_res;
	reg arith_sub;
	reg arith_cf;
	reg arith_of;
	reg [`FLAG_WIDTH-1:0] arith_flags;
	reg [`FLAG_WIDTH-1:0] cmp_flags;
	reg [63:0] sa;
	reg [63:0] sb;
	reg [63:0] sr;

	always @*
	begin
		case (opcode)
			`OP_MOV: logic_res = rb; // [RULE9]
			`OP_AND: logic_res = ra & rb;
			`OP_OR: logic_res = ra | rb;
			`OP_XOR: logic_res = ra ^ rb;
			`OP_ANDNOT: logic_res = ~ra & rb;
			`OP_ORNOT: logic_res = ~ra | rb;
			`OP_NAND: logic_res = ~(ra & rb);
			`OP_NOR: logic_res = ~(ra | rb);
			default: logic_res = ~(ra ^ rb);
		endcase
	end

	always @*
	begin
		arith_sub = (opcode == `OP_SUB) || (opcode == `OP_ADDS) || (opcode == `OP_SUBM)
			|| (opcode == `OP_SUBC) || (opcode == `OP_SET_SUB) || (opcode == `OP_COMPARE_DIFF_BRANCH);
		if (arith_sub)
			arith_full = {1'b0, am} - {1'b0, bm};
		else
			arith_full = {1'b0, am} + {1'b0, bm};
		case (opcode)
			`OP_ADDA, `OP_ADDS: arith_full = arith_full + {1'b0, shifted_c & msk}; // [RULE10]
			`OP_ADDC: arith_full = arith_full + {64'h0000000000000000, rc_flags[`FL_CF]}; // [RULE11]
			`OP_SUBC: arith_full = arith_full - {64'h0000000000000000, rc_flags[`FL_CF]}; // [RULE11]
			default: arith_full = arith_full;
		endcase
		arith_res = arith_full[63:0];
		if ((opcode == `OP_ADDM) || (opcode == `OP_SUBM))
			arith_res = arith_res & rc; // [RULE12]
		arith_cf = arith_full[{1'b0, tb} + 7'd1]; // [RULE6]
		sa = sign_extend_op(ra, tb);
		sb = sign_extend_op(rb, tb);
		sr = sign_extend_op(arith_full[63:0], tb);
		if (arith_sub)
			arith_of = (sa[63] != sb[63]) && (sr[63] != sa[63]);
		else
			arith_of = (sa[63] == sb[63]) && (sr[63] != sa[63]);
		arith_flags = zps_of(arith_res, size_shift_field);
		arith_flags[`FL_CF] = arith_cf;
		arith_flags[`FL_OF] = arith_of;
		if (opcode == `OP_SET_AND || opcode == `OP_COMPARE_MASK_BRANCH)
			cmp_flags = zps_of(ra & rb, size_shift_field);
		else
			cmp_flags = arith_flags;
	end

	// issue gating and per-uop result selection
	wire any_wait = ra_flags[`FL_WAIT] | rb_flags[`FL_WAIT] | rc_flags[`FL_WAIT];
	wire is_sel = (opcode == `OP_SEL);
	wire take_uop = uop_valid & ctrl_q[`CTRL_ENABLE_BIT] & ~(is_sel & any_wait); // [RULE15]
	wire any_inv = ra_flags[`FL_INV] | rb_flags[`FL_INV] | rc_flags[`FL_INV];

	reg [63:0] out_data;
	reg [`FLAG_WIDTH-1:0] out_flags;
	reg out_branch;
	reg cond_true;
	reg [63:0] target;
	reg [31:0] target_page;
	reg page_bad;

	always @*
	begin
		out_data = 64'h0000000000000000;
		out_flags = {`FLAG_WIDTH{1'b0}};
		out_branch = 1'b0;
		cond_true = 1'b0;
		case (opcode)
			`OP_MOV, `OP_AND, `OP_OR, `OP_XOR, `OP_ANDNOT, `OP_ORNOT, `OP_NAND, `OP_NOR, `OP_XNOR:
			begin
				out_data = merge(logic_res, ra, size_shift_field); // [RULE9]
				out_flags = zps_of(logic_res, size_shift_field);
				out_flags[`FL_INV] = any_inv;
			end
			`OP_ADD, `OP_SUB, `OP_ADDA, `OP_ADDS, `OP_ADDM, `OP_SUBM, `OP_ADDC, `OP_SUBC:
			begin
				out_data = merge(arith_res, ra, size_shift_field); // [RULE10]
				out_flags = arith_flags;
				out_flags[`FL_INV] = any_inv;
			end
			`OP_SEL:
			begin
				cond_true = flag_condition_eval(rc_flags, cond_code);
				out_data = merge(cond_true ? rb : ra, ra, size_shift_field); // [RULE13]
				out_flags = cond_true ? rb_flags : ra_flags; // [RULE13]
				out_flags[`FL_INV] = rc_flags[`FL_INV] | (cond_true ? rb_flags[`FL_INV] : ra_flags[`FL_INV]); // [RULE14]
			end
			`OP_SET:
			begin
				cond_true = flag_condition_eval(rc_flags, cond_code);
				out_data = merge({63'd0, cond_true}, rb, size_shift_field); // [RULE16]
				out_flags = rc_flags; // [RULE16]
				out_flags[`FL_INV] = any_inv;
			end
			`OP_SET_SUB, `OP_SET_AND:
			begin
				cond_true = flag_condition_eval(cmp_flags, cond_code);
				out_data = merge({63'd0, cond_true}, rc, size_shift_field); // [RULE17]
				out_flags = cmp_flags; // [RULE17]
				out_flags[`FL_INV] = any_inv;
			end
			`OP_BR:
			begin
				out_branch = 1'b1;
				cond_true = flag_condition_eval(ra_flags, cond_code); // [RULE18]
			end
			`OP_COMPARE_DIFF_BRANCH, `OP_COMPARE_MASK_BRANCH:
			begin
				out_branch = 1'b1;
				cond_true = flag_condition_eval(cmp_flags, cond_code);
				out_flags = cmp_flags; // [RULE22]
				out_flags[`FL_INV] = any_inv;
			end
			default:
			begin
				out_flags[`FL_INV] = 1'b1;
			end
		endcase
		// the decoder has already swapped targets for not-taken predictions [RULE20]
		target = cond_true ? rip_taken : rip_seq; // [RULE18]
		target_page = target[`PAGE_LSB+31:`PAGE_LSB];
		page_bad = ctrl_q[`CTRL_FAULT_CHECK_BIT] &
			((target_page < page_base_q) || (target_page > page_limit_q)); // [RULE21]
	end

	wire br_misp = take_uop & out_branch & ~cond_true;
	wire br_fault = take_uop & out_branch & page_bad;

	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			res_valid <= 1'b0;
			res_refused <= 1'b0;
			res_data <= 64'h0000000000000000;
			res_flags <= {`FLAG_WIDTH{1'b0}};
			rip_write <= 1'b0;
			rip_next <= 64'h0000000000000000;
			mispredict_exception <= 1'b0;
			exec_page_fault <= 1'b0;
		end
		else
		begin
			res_valid <= take_uop;
			res_refused <= uop_valid & ~take_uop;
			rip_write <= take_uop & out_branch;
			mispredict_exception <= br_misp; // [RULE19]
			exec_page_fault <= br_fault; // [RULE21]
			if (take_uop)
			begin
				res_data <= out_branch ? target : out_data;
				res_flags <= out_flags;
				rip_next <= out_branch ? target : rip_next;
			end
		end
	end

	// apb: one wait-free access, read data captured in setup
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			ctrl_q <= `CTRL_RESET;
			page_base_q <= `PAGE_BASE_RESET;
			page_limit_q <= `PAGE_LIMIT_RESET;
			misp_count_q <= 32'h00000000;
			fault_count_q <= 32'h00000000;
		end
		else
		begin
			pready <= apb_setup;
			pslverr <= apb_setup & ~addr_hit;
			if (apb_setup)
				prdata <= rd_mux;
			if (apb_write && paddr == `REG_CTRL)
				ctrl_q <= pwdata & 32'h00000003;
			if (apb_write && paddr == `REG_PAGE_BASE)
				page_base_q <= pwdata;
			if (apb_write && paddr == `REG_PAGE_LIMIT)
				page_limit_q <= pwdata;
			// a write clears the counter; an event in the same cycle still counts
			if (apb_write && paddr == `REG_MISP_COUNT)
				misp_count_q <= {31'd0, br_misp};
			else if (br_misp)
				misp_count_q <= misp_count_q + 32'h00000001;
			if (apb_write && paddr == `REG_FAULT_COUNT)
				fault_count_q <= {31'd0, br_fault};
			else if (br_fault)
				fault_count_q <= fault_count_q + 32'h00000001;
		end
	end

endmodule // uop_alu_branch_unit

// >>> uop_alu_branch_unit_asserts.sv
// concurrent checks on the execute unit ports
`timescale 1ns/1ns
`include "uop_alu_defines.vh"
module uop_alu_checker #(
	parameter DATA_W = 64
) (
	// clock and reset
	input wire clk,
	input wire arst_n,
	// uop side
	input wire uop_valid,
	input wire [4:0] opcode,
	input wire [1:0] size_shift_field,
	input wire [DATA_W-1:0] ra,
	input wire [DATA_W-1:0] rb,
	input wire [`FLAG_WIDTH-1:0] ra_flags,
	input wire [`FLAG_WIDTH-1:0] rb_flags,
	input wire [`FLAG_WIDTH-1:0] rc_flags,
	input wire [DATA_W-1:0] rip_taken,
	input wire [DATA_W-1:0] rip_seq,
	// result side
	input wire res_valid,
	input wire res_refused,
	input wire [DATA_W-1:0] res_data,
	input wire [`FLAG_WIDTH-1:0] res_flags,
	input wire rip_write,
	input wire [DATA_W-1:0] rip_next,
	input wire mispredict_exception,
	input wire exec_page_fault
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_result_has_cause: assert property ((res_valid || res_refused) |-> $past(uop_valid))
		else $error("result without uop");
	a_sel_wait_refused: assert property (uop_valid && opcode == `OP_SEL && (ra_flags[`FL_WAIT] ||
		rb_flags[`FL_WAIT] || rc_flags[`FL_WAIT]) |=> res_refused && !res_valid) else $error("waiting select issued");
	a_br_target: assert property (rip_write |-> res_data == rip_next &&
		rip_next == (mispredict_exception ? $past(rip_seq) : $past(rip_taken))) else $error("bad branch target");
	a_misp_branch: assert property (mispredict_exception |-> rip_write && rip_next == $past(rip_seq))
		else $error("mispredict without sequential target");
	a_br_no_flags: assert property (rip_write && $past(opcode) == `OP_BR |-> res_flags == 0)
		else $error("plain branch made flags");
	a_fault_branch: assert property (exec_page_fault |-> rip_write)
		else $error("page fault without branch");
	a_size0_merge: assert property (res_valid && $past(size_shift_field) == 2'h0 && $past(opcode) <= `OP_SUBC
		|-> (res_data >> 8) == ($past(ra) >> 8)) else $error("byte merge lost upper bytes");
	a_size3_xor: assert property (res_valid && $past(opcode) == `OP_XOR && $past(size_shift_field) == 2'h3
		|-> res_data == ($past(ra) ^ $past(rb))) else $error("full width xor wrong");
endmodule // uop_alu_checker
bind uop_alu_branch_unit uop_alu_checker #(.DATA_W(DATA_W)) uop_alu_checker_inst (.clk, .arst_n, .uop_valid, .opcode,
	.size_shift_field, .ra, .rb, .ra_flags, .rb_flags, .rc_flags, .rip_taken, .rip_seq, .res_valid, .res_refused,
	.res_data, .res_flags, .rip_write, .rip_next, .mispredict_exception, .exec_page_fault);

// >>> issue_model.sv
// issue-side model folding the branch guess into targets and condition
`timescale 1ns/1ns
module issue_model (
	// guess and raw fields
	input wire logic pred_taken,
	input wire logic [3:0] cc_in,
	input wire logic [63:0] tgt,
	input wire logic [63:0] seq,
	// fields to the unit
	output logic [3:0] cond_code,
	output logic [63:0] rip_taken,
	output logic [63:0] rip_seq
);
	// the unit assumes taken, so a not-taken guess swaps and inverts
	assign cond_code = {cc_in[3:1], cc_in[0] ^ !pred_taken};
	assign rip_taken = pred_taken ? tgt : seq;
	assign rip_seq = pred_taken ? seq : tgt;
endmodule // issue_model

// >>> uop_alu_branch_unit_tb.sv
// self-checking bench for the integer execute unit
`timescale 1ns/1ns
`include "uop_alu_defines.vh"
module uop_alu_branch_unit_tb;
	typedef struct {logic [4:0] op; logic [1:0] sz; logic [1:0] sh; logic [63:0] a, b, c; logic cf; logic [63:0] x;} row_t;
	logic clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, uop_valid = 0, pred_taken = 1, e, t;
	logic pready, pslverr, res_valid, res_refused, rip_write, mispredict_exception, exec_page_fault;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, r, prdata;
	logic [4:0] opcode = 0;
	logic [1:0] size_shift_field = 0, shift_amount = 0;
	logic [3:0] cc_in = 0, cond_code;
	logic [63:0] ra = 0, rb = 0, rc = 0, tgt = 64'h2000, seq = 64'h3000, rip_taken, rip_seq, res_data, rip_next;
	logic [6:0] ra_flags = 0, rb_flags = 0, rc_flags = 0, res_flags;
	int errors = 0, comparisons = 0;
	row_t rows [17] = '{'{`OP_MOV, 0, 0, 64'hAB00000000000012, 64'h34, 0, 0, 64'hAB00000000000034},
		'{`OP_AND, 1, 0, 64'hAB0000000000F0F0, 64'hFF0F, 0, 0, 64'hAB0000000000F000},
		'{`OP_OR, 2, 0, 64'hAB000000F0000000, 64'h0F, 0, 0, 64'hF000000F},
		'{`OP_XOR, 3, 0, 64'hF0, 64'hFF, 0, 0, 64'h0F}, '{`OP_ANDNOT, 3, 0, 64'hF0, 64'hFF, 0, 0, 64'h0F},
		'{`OP_ORNOT, 3, 0, 64'hFFFFFFFFFFFFFFF0, 0, 0, 0, 64'h0F}, '{`OP_NAND, 0, 0, 64'h0F, 64'h0C, 0, 0, 64'hF3},
		'{`OP_NOR, 0, 0, 64'h1F0, 64'h0F, 0, 0, 64'h100}, '{`OP_XNOR, 1, 0, 64'h5A, 64'h5A, 0, 0, 64'hFFFF},
		'{`OP_ADD, 0, 0, 64'h1FF, 1, 0, 0, 64'h100}, '{`OP_SUB, 1, 0, 64'h70005, 7, 0, 0, 64'h7FFFE},
		'{`OP_ADDA, 3, 2, 64'h10, 64'h20, 3, 0, 64'h3C}, '{`OP_ADDS, 3, 1, 64'h100, 64'h10, 4, 0, 64'hF8},
		'{`OP_ADDM, 3, 0, 64'hFFF, 1, 64'h1FFF, 0, 64'h1000}, '{`OP_SUBM, 3, 0, 0, 1, 64'hFF, 0, 64'hFF},
		'{`OP_ADDC, 3, 0, 1, 1, 5, 1, 3}, '{`OP_SUBC, 3, 0, 64'hA, 3, 7, 1, 6}};
	always #10 clk = ~clk;
	issue_model issue_model_inst (.pred_taken, .cc_in, .tgt, .seq, .cond_code, .rip_taken, .rip_seq);
	uop_alu_branch_unit uop_alu_branch_unit_inst (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .uop_valid, .opcode, .size_shift_field, .cond_code, .shift_amount, .ra, .rb, .rc, .ra_flags,
		.rb_flags, .rc_flags, .rip_taken, .rip_seq, .res_valid, .res_refused, .res_data, .res_flags, .rip_write,
		.rip_next, .mispredict_exception, .exec_page_fault);
	task test_done;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [63:0] x, input logic [63:0] g);
		comparisons++;
		if (g !== x)
		begin
			$display("[FAIL] %s expected %h seen %h", n, x, g);
			errors++;
		end
	endtask
	// reference condition: bit order follows cond_code[3:1]
	function automatic logic ev(input logic [3:0] cc, input logic [6:0] f);
		logic [7:0] m;
		m = {f[1] | (f[3] ^ f[4]), f[3] ^ f[4], f[2], f[3], f[0] | f[1], f[1], f[0], f[4]};
		return m[cc[3:1]] ^ cc[0];
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// answer taken at the edge that finds pready high, request released there
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			errors++;
			test_done;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// result pulse stands one cycle after the taking edge, so look just after it
	task automatic issue(input logic [4:0] op, input logic [1:0] sz, sh, input logic [3:0] cc,
		input logic [63:0] a, b, c, input logic [6:0] fa, fb, fc);
		@(posedge clk);
		uop_valid <= 1'b1;
		opcode <= op;
		size_shift_field <= sz;
		shift_amount <= sh;
		cc_in <= cc;
		ra <= a;
		rb <= b;
		rc <= c;
		ra_flags <= fa;
		rb_flags <= fb;
		rc_flags <= fc;
		@(posedge clk);
		uop_valid <= 1'b0;
		#1;
	endtask
	initial
	begin
		repeat (10) @(posedge clk);
		chk("reset valid", 0, res_valid);
		arst_n <= 1'b1;
		apb(0, `REG_CTRL, 0);
		chk("ctrl reset", 32'h3, r);
		chk("ctrl error", 0, e);
		apb(0, 8'h20, 0);
		chk("unmapped", 1, e);
		$display("test reset done");
		foreach (rows[i])
		begin
			issue(rows[i].op, rows[i].sz, rows[i].sh, 0, rows[i].a, rows[i].b, rows[i].c, 0, 0, {6'h0, rows[i].cf});
			chk("row", rows[i].x, res_data);
			chk("row valid", 1, res_valid);
		end
		issue(`OP_ADD, 0, 0, 0, 64'h1FF, 1, 0, 0, 0, 0);
		chk("narrow flags", 7'h07, res_flags);
		$display("test rows done");
		for (int k = 0; k < 32; k++)
		begin
			t = ev(k[3:0], k[4] ? 7'h09 : 7'h16);
			issue(`OP_BR, 3, 0, k[3:0], 0, 0, 0, k[4] ? 7'h09 : 7'h16, 0, 0);
			chk("mispredict", !t, mispredict_exception);
			chk("target", t ? tgt : seq, rip_next);
			chk("branch write", 1, rip_write);
			chk("branch flags", 0, res_flags);
		end
		pred_taken <= 0;
		issue(`OP_BR, 3, 0, 4'h4, 0, 0, 0, 7'h02, 0, 0);
		chk("not taken", tgt, rip_next);
		pred_taken <= 1;
		for (int j = 0; j < 2; j++)
		begin
			issue(j ? `OP_COMPARE_MASK_BRANCH : `OP_COMPARE_DIFF_BRANCH, 3, 0, 4'h4, j ? 64'hF0 : 3, j ? 64'h0F : 3, 0, 0, 0, 0);
			chk("fused target", tgt, rip_next);
			chk("fused flags", 7'h06, res_flags);
			issue(j ? `OP_SET_AND : `OP_SET_SUB, 0, 0, 4'h4, j ? 64'hF0 : 5, j ? 64'h0F : 5, 64'hCDFF, 0, 0, 0);
			chk("fused set", 64'hCD01, res_data);
			chk("fused set flags", 7'h06, res_flags);
		end
		// one of each inverted pair fails: 16 from the loop, 1 from the not-taken guess
		apb(0, `REG_MISP_COUNT, 0);
		chk("mispredict count", 32'h11, r);
		apb(1, `REG_MISP_COUNT, 0);
		apb(0, `REG_MISP_COUNT, 0);
		chk("count cleared", 0, r);
		$display("test branch done");
		issue(`OP_SET, 0, 0, 4'h4, 0, 64'hAB00, 0, 7'h02, 0, 7'h02);
		chk("set", 64'hAB01, res_data);
		chk("set flags", 7'h02, res_flags);
		issue(`OP_SEL, 3, 0, 4'h4, 64'hA, 64'hB, 0, 7'h20, 7'h01, 7'h02);
		chk("select", 64'hB, res_data);
		chk("select flags", 7'h01, res_flags);
		issue(`OP_SEL, 3, 0, 4'h4, 64'hA, 64'hB, 0, 0, 0, 7'h22);
		chk("select cond invalid", 7'h20, res_flags);
		issue(`OP_SEL, 3, 0, 4'h4, 64'hA, 64'hB, 0, 7'h40, 0, 7'h02);
		chk("select waiting", 1, res_refused);
		apb(1, `REG_PAGE_LIMIT, 0);
		issue(`OP_BR, 3, 0, 4'h4, 0, 0, 0, 7'h02, 0, 0);
		chk("page fault", 1, exec_page_fault);
		apb(0, `REG_FAULT_COUNT, 0);
		chk("fault count", 1, r);
		apb(1, `REG_CTRL, 0);
		issue(`OP_MOV, 3, 0, 0, 0, 1, 0, 0, 0, 0);
		chk("disabled", 1, res_refused);
		@(posedge clk);
		arst_n <= 1'b0;
		@(posedge clk);
		chk("reset refused", 0, res_refused);
		arst_n <= 1'b1;
		apb(0, `REG_CTRL, 0);
		chk("ctrl after reset", 32'h3, r);
		$display("test special done");
		test_done;
	end
endmodule // uop_alu_branch_unit_tb
